// ===== ptcp_app_model.sv
`timescale 1ns/100ps
`default_nettype none
module ptcp_app_model (
  // Clock
  input  wire logic  i_sys_clk,
  // Debug intent
  input  wire logic  i_accel,
  input  wire logic  i_block,
  input  wire logic  i_force,
  // Test control bus
  output logic [31:0] o_test_ctrl
);
  // Registered so the bus only moves just after an edge
  always_ff @(posedge i_sys_clk)
  begin
    o_test_ctrl <= {25'h0, i_force, i_block, 4'h0, i_accel};
  end
endmodule
`default_nettype wire

// ===== ptcp_chk.sv
`timescale 1ns/100ps
`default_nettype none
module ptcp_chk #(
  parameter int POLL_TIMEOUT_CYC = 64,
  parameter int NUM_LANES        = 8
) (
  // Clock and reset
  input wire logic                                i_sys_clk,
  input wire logic                                i_rst,
  // Inputs
  input wire logic [31:0]                         i_test_ctrl,
  input wire logic                                i_pipe_sim,
  input wire logic [NUM_LANES-1:0][2:0]           i_tx_level,
  input wire logic [NUM_LANES-1:0]                i_tx_swing,
  // Outputs
  input wire ptcp_pkg::ptcp_tx_lane_t [NUM_LANES-1:0] o_tx_lane,
  input wire logic                                o_sim_mode_pipe,
  input wire logic [3:0]                          o_lane_active,
  input wire logic                                o_in_compliance,
  input wire logic                                o_sim_accel,
  input wire logic [2:0]                          o_ltssm_state,
  input wire logic [31:0]                         o_test_obs
);
  // Edges since release; $past must not reach into reset
  logic [1:0] age_r;
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      age_r <= 2'h0;
    else if (age_r != 2'h3)
      age_r <= age_r + 2'h1;
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  for (genvar g = 0; g < NUM_LANES; g++)
  begin : g_lane
    property p_lane;
      age_r != 2'h0 |-> o_tx_lane[g] == {($past(i_tx_level[g]) inside
        {3'h2, 3'h3}) ? 3'h0 : $past(i_tx_level[g]), $past(i_tx_swing[g])};
    endproperty
    a_lane: assert property (p_lane)
      else $error("lane output mismatch");
  end
  property p_accel;
    age_r == 2'h3 |-> o_sim_accel == $past(i_test_ctrl[0], 3);
  endproperty
  a_accel: assert property (p_accel)
    else $error("accel flag mismatch");
  property p_block;
    age_r == 2'h3 && $past(i_test_ctrl[5], 3) |-> !o_in_compliance;
  endproperty
  a_block: assert property (p_block)
    else $error("compliance not blocked");
  property p_cflag;
    o_in_compliance == (o_ltssm_state == ptcp_pkg::PTCP_COMPLIANCE);
  endproperty
  a_cflag: assert property (p_cflag)
    else $error("compliance flag mismatch");
  property p_sim;
    age_r != 2'h0 |-> o_sim_mode_pipe == $past(i_pipe_sim);
  endproperty
  a_sim: assert property (p_sim)
    else $error("sim mode mismatch");
  property p_onehot;
    o_lane_active inside {4'h0, 4'h1, 4'h2, 4'h4};
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("lane count code illegal");
  property p_lzero;
    o_lane_active != 4'h0 |-> o_ltssm_state == ptcp_pkg::PTCP_L0 ||
      $past(o_ltssm_state) == ptcp_pkg::PTCP_L0;
  endproperty
  a_lzero: assert property (p_lzero)
    else $error("lane count before training");
  property p_obs;
    o_test_obs == 32'h0;
  endproperty
  a_obs: assert property (p_obs)
    else $error("observation bus not quiet");
endmodule
bind ptcp_test_port ptcp_chk #(.POLL_TIMEOUT_CYC(POLL_TIMEOUT_CYC),
  .NUM_LANES(NUM_LANES)) u_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
  .i_test_ctrl(i_test_ctrl), .i_pipe_sim(i_pipe_sim),
  .i_tx_level(i_tx_level), .i_tx_swing(i_tx_swing), .o_tx_lane(o_tx_lane),
  .o_sim_mode_pipe(o_sim_mode_pipe), .o_lane_active(o_lane_active),
  .o_in_compliance(o_in_compliance), .o_sim_accel(o_sim_accel),
  .o_ltssm_state(o_ltssm_state), .o_test_obs(o_test_obs));
`default_nettype wire

// ===== ptcp_lane_margin.sv
`timescale 1ns/100ps
`default_nettype none
module ptcp_lane_margin (
  // Clock and reset
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rst,
  // Request
  input  wire logic [2:0]            i_level,
  input  wire logic                  i_swing,
  // To PHY
  output var ptcp_pkg::ptcp_tx_lane_t o_tx
);
  logic [2:0] lvl_nxt;

  // Reserved codes are replaced by the normal level (LVL_NORMAL), never issued
  always_comb
  begin
    lvl_nxt = i_level;
    if (i_level == ptcp_pkg::LVL_RSVD_A || i_level == ptcp_pkg::LVL_RSVD_B)
    begin
      lvl_nxt = ptcp_pkg::LVL_NORMAL;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_tx.level <= ptcp_pkg::LVL_NORMAL;
      o_tx.swing <= 1'b0;
    end
    else
    begin
      o_tx.level <= lvl_nxt;
      o_tx.swing <= i_swing;
    end
  end
endmodule
`default_nettype wire

// ===== ptcp_pkg.sv
package ptcp_pkg;

  // Test control bus layout
  localparam int TC_WIDTH        = 32;
  localparam int TC_SIM_BIT      = 0;
  localparam int TC_RSVD_LO      = 1;
  localparam int TC_RSVD_HI      = 4;
  localparam int TC_NO_COMPL_BIT = 5;
  localparam int TC_FORCE_COMPL_BIT = 6;

  // Lanes and encodings
  localparam int NUM_LANES = 8;
  localparam logic [2:0] LVL_NORMAL = 3'h0;
  localparam logic [2:0] LVL_RSVD_A = 3'h2;
  localparam logic [2:0] LVL_RSVD_B = 3'h3;
  localparam logic [3:0] LANES_NONE = 4'h0;
  localparam logic [3:0] LANES_X1   = 4'h1;
  localparam logic [3:0] LANES_X2   = 4'h2;
  localparam logic [3:0] LANES_X4   = 4'h4;

  // Polling.active timeout, normal and accelerated
  localparam int  CLK_MHZ          = 20;
  localparam int  POLL_TIMEOUT_US  = 24000;
  localparam int  POLL_TIMEOUT_CYC = POLL_TIMEOUT_US * CLK_MHZ;
  localparam int  SIM_POLL_CYC     = 16;
  localparam int  TMR_W            = 20;

  typedef enum logic [2:0] {
    PTCP_DETECT     = 3'h0,
    PTCP_POLL       = 3'h1,
    PTCP_COMPLIANCE = 3'h5,
    PTCP_CONFIG     = 3'h3,
    PTCP_L0         = 3'h2
  } ptcp_state_t;

  typedef struct packed {
    logic [2:0] level;
    logic       swing;
  } ptcp_tx_lane_t;

endpackage

// ===== ptcp_test_port.sv
`timescale 1ns/100ps
`default_nettype none
module ptcp_test_port #(
  parameter int POLL_TIMEOUT_CYC = ptcp_pkg::POLL_TIMEOUT_CYC,
  parameter int NUM_LANES        = ptcp_pkg::NUM_LANES
) (
  // Clock and reset
  input  wire logic                          i_sys_clk,
  input  wire logic                          i_rst,
  // Test control bus from fabric
  input  wire logic [31:0]                   i_test_ctrl,
  // Link training inputs from the link layer
  input  wire logic                          i_link_start,
  input  wire logic [NUM_LANES-1:0]          i_lane_exit_det,
  input  wire logic                          i_train_done,
  input  wire logic [3:0]                    i_neg_width,
  input  wire logic                          i_pipe_sim,
  // Per-lane transmit requests
  input  wire logic [NUM_LANES-1:0][2:0]     i_tx_level,
  input  wire logic [NUM_LANES-1:0]          i_tx_swing,
  // Per-lane transmit controls to the PHY
  output wire ptcp_pkg::ptcp_tx_lane_t [NUM_LANES-1:0] o_tx_lane,
  // Status
  output logic                               o_sim_mode_pipe,
  output logic [3:0]                         o_lane_active,
  output logic                               o_in_compliance,
  output logic                               o_sim_accel,
  output logic [2:0]                         o_ltssm_state,
  output logic [31:0]                        o_test_obs
);
  logic [31:0]            tc_meta_r;
  logic [31:0]            tc_r;
  logic [NUM_LANES-1:0]   det_meta_r;
  logic [NUM_LANES-1:0]   det_r;
  logic                   no_compl_d_r;
  logic [ptcp_pkg::TMR_W-1:0] tmr_r;
  logic [ptcp_pkg::TMR_W-1:0] tmr_lim;
  ptcp_pkg::ptcp_state_t  st_r;
  ptcp_pkg::ptcp_state_t  st_nxt;
  logic                   timeout;
  logic                   all_det;
  logic                   sim_on;
  logic                   no_compl;
  logic                   force_compl;

  // Test bus and lane detect come from outside logic of unknown timing
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      tc_meta_r  <= 32'h0;
      tc_r       <= 32'h0;
      det_meta_r <= '0;
      det_r      <= '0;
    end
    else
    begin
      tc_meta_r  <= i_test_ctrl;
      tc_r       <= tc_meta_r;
      det_meta_r <= i_lane_exit_det;
      det_r      <= det_meta_r;
    end
  end

  assign sim_on      = tc_r[ptcp_pkg::TC_SIM_BIT];
  assign no_compl    = tc_r[ptcp_pkg::TC_NO_COMPL_BIT];
  assign force_compl = tc_r[ptcp_pkg::TC_FORCE_COMPL_BIT];
  assign all_det     = &det_r;

  assign tmr_lim = sim_on ? ptcp_pkg::TMR_W'(ptcp_pkg::SIM_POLL_CYC)
                          : ptcp_pkg::TMR_W'(POLL_TIMEOUT_CYC);
  assign timeout = (tmr_r >= tmr_lim - 1'b1);

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      tmr_r <= '0;
    end
    else if (st_r == ptcp_pkg::PTCP_POLL && !timeout)
    begin
      tmr_r <= tmr_r + 1'b1;
    end
    else if (st_r != ptcp_pkg::PTCP_POLL)
    begin
      tmr_r <= '0;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      no_compl_d_r <= 1'b0;
    end
    else
    begin
      no_compl_d_r <= no_compl;
    end
  end

  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      ptcp_pkg::PTCP_DETECT:
      begin
        if (i_link_start)
        begin
          st_nxt = ptcp_pkg::PTCP_POLL;
        end
      end
      ptcp_pkg::PTCP_POLL:
      begin
        if (all_det)
        begin
          st_nxt = ptcp_pkg::PTCP_CONFIG;
        end
        else if (timeout && force_compl && !no_compl)
        begin
          st_nxt = ptcp_pkg::PTCP_COMPLIANCE;
        end
        else if (timeout)
        begin
          st_nxt = ptcp_pkg::PTCP_DETECT;
        end
      end
      ptcp_pkg::PTCP_COMPLIANCE:
      begin
        if (no_compl)
        begin
          st_nxt = ptcp_pkg::PTCP_POLL;
        end
      end
      ptcp_pkg::PTCP_CONFIG:
      begin
        if (i_train_done)
        begin
          st_nxt = ptcp_pkg::PTCP_L0;
        end
      end
      ptcp_pkg::PTCP_L0:
      begin
        if (!i_link_start)
        begin
          st_nxt = ptcp_pkg::PTCP_DETECT;
        end
      end
      default:
      begin
        st_nxt = ptcp_pkg::PTCP_DETECT;
      end
    endcase
    // falling edge of block in Polling enters compliance
    if (no_compl_d_r && !no_compl && st_r == ptcp_pkg::PTCP_POLL)
    begin
      st_nxt = ptcp_pkg::PTCP_COMPLIANCE;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_r <= ptcp_pkg::PTCP_DETECT;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_lane_active <= ptcp_pkg::LANES_NONE;
    end
    else if (st_r != ptcp_pkg::PTCP_L0)
    begin
      o_lane_active <= ptcp_pkg::LANES_NONE;
    end
    else
    begin
      case (i_neg_width)
        ptcp_pkg::LANES_X1: o_lane_active <= ptcp_pkg::LANES_X1;
        ptcp_pkg::LANES_X2: o_lane_active <= ptcp_pkg::LANES_X2;
        ptcp_pkg::LANES_X4: o_lane_active <= ptcp_pkg::LANES_X4;
        default:            o_lane_active <= ptcp_pkg::LANES_NONE;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_sim_mode_pipe <= 1'b0;
      o_in_compliance <= 1'b0;
      o_sim_accel     <= 1'b0;
      o_ltssm_state   <= 3'h0;
      o_test_obs      <= 32'h0;
    end
    else
    begin
      o_sim_mode_pipe <= i_pipe_sim;
      o_in_compliance <= (st_nxt == ptcp_pkg::PTCP_COMPLIANCE);
      o_sim_accel     <= sim_on;
      o_ltssm_state   <= st_nxt;
      o_test_obs      <= 32'h0;
    end
  end

  for (genvar g = 0; g < NUM_LANES; g++)
  begin : g_lane
    ptcp_lane_margin u_margin (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_level   (i_tx_level[g]),
      .i_swing   (i_tx_swing[g]),
      .o_tx      (o_tx_lane[g])
    );
  end
endmodule
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic acc = 1'b0, blk = 1'b0, frc = 1'b0, start = 1'b0, done = 1'b0;
  logic pipe_sim = 1'b0, ep, in_compl, accel, sim_pipe;
  logic [7:0] det = '0, swing = '0;
  logic [7:0][2:0] level = '0;
  logic [7:0][3:0] e;
  logic [3:0] width = '0, lane_act;
  logic [3:0] wid [4] = '{4'h1, 4'h2, 4'h4, 4'h3};
  logic [2:0] st;
  logic [31:0] tc, obs;
  ptcp_pkg::ptcp_tx_lane_t [7:0] tx;
  int err_count, checks, n, seed = 32'ha76f4fb0;
  ptcp_app_model u_app (.i_sys_clk(i_sys_clk), .i_accel(acc), .i_block(blk),
    .i_force(frc), .o_test_ctrl(tc));
  ptcp_test_port #(.POLL_TIMEOUT_CYC(64)) dut (.i_sys_clk(i_sys_clk),
    .i_rst(i_rst), .i_test_ctrl(tc), .i_link_start(start),
    .i_lane_exit_det(det), .i_train_done(done), .i_neg_width(width),
    .i_pipe_sim(pipe_sim), .i_tx_level(level), .i_tx_swing(swing),
    .o_tx_lane(tx), .o_sim_mode_pipe(sim_pipe), .o_lane_active(lane_act),
    .o_in_compliance(in_compl), .o_sim_accel(accel), .o_ltssm_state(st),
    .o_test_obs(obs));
  initial
    forever #25 i_sys_clk = ~i_sys_clk;
  function automatic logic [3:0] exp_lane(input logic [2:0] l, input logic s);
    return {(l inside {3'h2, 3'h3}) ? 3'h0 : l, s};
  endfunction
  function automatic logic [3:0] exp_w(input logic [3:0] w);
    return (w inside {4'h1, 4'h2, 4'h4}) ? w : 4'h0;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("err_count=%0d checks=%0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic go(input int c);
    repeat (c) @(posedge i_sys_clk);
  endtask
  task automatic do_reset;
    go(1);
    i_rst <= 1'b1;
    {start, done, det, acc, blk, frc} <= '0;
    go(5);
    i_rst <= 1'b0;
    go(1);
  endtask
  // Bounded wait, sampled mid-cycle away from the launch edge
  task automatic wait_st(input logic [2:0] s);
    n = 0;
    do
    begin
      @(negedge i_sys_clk);
      n++;
    end
    while (st !== s && n < 300);
    chk(32'(st), 32'(s));
    if (n >= 300)
      results();
  endtask
  initial
  begin
    do_reset();
    for (int i = 0; i < 60; i++)
    begin
      go(1);
      {level, swing, pipe_sim} <= 33'({$random(seed), $random(seed)});
      @(negedge i_sys_clk);
      for (int g = 0; g < 8; g++)
      begin
        if (i > 0) chk(32'(tx[g]), 32'(e[g]));
        e[g] = exp_lane(level[g], swing[g]);
      end
      if (i > 0) chk(32'(sim_pipe), 32'(ep));
      ep = pipe_sim;
    end
    chk(obs, 32'h0);
    // Timeout well under the 64-cycle normal limit proves the speed-up
    for (int f = 0; f < 3; f++)
    begin
      do_reset();
      acc <= (f != 0);
      frc <= (f != 1);
      go(5);
      start <= 1'b1;
      go(30);
      @(negedge i_sys_clk);
      chk(32'(in_compl), 32'(f == 2));
      chk(32'(accel), 32'(f != 0));
    end
    go(1);
    blk <= 1'b1;
    wait_st(ptcp_pkg::PTCP_POLL);
    // Forced entry must stay blocked across several timeouts
    go(40);
    @(negedge i_sys_clk);
    chk(32'(in_compl), 32'h0);
    go(1);
    blk <= 1'b0;
    wait_st(ptcp_pkg::PTCP_COMPLIANCE);
    foreach (wid[k])
    begin
      do_reset();
      acc <= 1'b1;
      width <= wid[k];
      start <= 1'b1;
      det <= 8'hff;
      wait_st(ptcp_pkg::PTCP_CONFIG);
      chk(32'(lane_act), 32'h0);
      go(1);
      done <= 1'b1;
      wait_st(ptcp_pkg::PTCP_L0);
      go(2);
      @(negedge i_sys_clk);
      chk(32'(lane_act), 32'(exp_w(wid[k])));
      // Dropping the link request leaves L0 and clears the count
      go(1);
      start <= 1'b0;
      wait_st(ptcp_pkg::PTCP_DETECT);
      go(1);
      @(negedge i_sys_clk);
      chk(32'(lane_act), 32'h0);
    end
    results();
  end
endmodule
`default_nettype wire
